// *** dv/sfsl_fault_log_asserts.sv ***
// Concurrent checks on the fault status and log block ports.
`timescale 1ns/1ps
module sfsl_fault_log_asserts #(
  parameter int CLEAR_CYC = 100000,
  parameter int SAVE_CYC  = 100000,
  parameter int LOAD_CYC  = 2000
) (
  input wire logic        CLK,
  input wire logic        SYS_RST,
  input wire logic        CMD_VALID,
  input wire logic [7:0]  CMD_CODE,
  input wire logic        CMD_ACK,
  input wire logic [15:0] RD_DATA,
  input wire logic        BUSY,
  input wire logic [5:0]  CMP_ABOVE_HI,
  input wire logic [5:0]  CMP_ABOVE_LO,
  input wire logic [5:0]  HIGH_COMPARE_POLARITY,
  input wire logic [5:0]  LOW_COMPARE_POLARITY,
  input wire logic [2:0]  INPUT1_FUNCTION_SELECT,
  input wire logic [2:0]  INPUT2_FUNCTION_SELECT,
  input wire logic        CFG_LOAD,
  input wire logic        RAIL_UVLO,
  input wire logic [2:0]  GPIO_OUT
);
  localparam int BUSY_MAX = CLEAR_CYC + SAVE_CYC + LOAD_CYC;
  logic [15:0] live_w;
  logic        plain_w;
  int          busy_n;
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  assign plain_w = {INPUT1_FUNCTION_SELECT, INPUT2_FUNCTION_SELECT} == 6'h00;
  // Expected live word: a bit faults when comparator output equals polarity.
  always_comb begin
    live_w = 16'h0000;
    for (int i = 0; i < 6; i++) begin
      live_w[2*i+2] = ~(CMP_ABOVE_HI[i] ^ HIGH_COMPARE_POLARITY[i]);
      live_w[2*i+1] = ~(CMP_ABOVE_LO[i] ^ LOW_COMPARE_POLARITY[i]);
    end
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST || !BUSY) busy_n <= 0;
    else busy_n <= busy_n + 1;
  end
  ack_when_idle_a: assert property (CMD_ACK == (CMD_VALID && !BUSY))
    else $error("ack does not follow idle request");
  busy_after_cmd_a: assert property (CMD_ACK && CMD_CODE inside
    {8'h1b, 8'h1c, 8'h1d} |=> BUSY) else $error("command did not start");
  busy_bounded_a: assert property (busy_n <= BUSY_MAX)
    else $error("busy lasts too long");
  live_read_a: assert property (CMD_ACK && CMD_CODE == 8'h1f && plain_w
    |=> RD_DATA == $past(live_w)) else $error("live word wrong");
  history_keeps_a: assert property (CMD_ACK && CMD_CODE == 8'h11 && plain_w
    && $stable(live_w) |=> (RD_DATA & $past(live_w)) == $past(live_w))
    else $error("history lost a present fault");
  reserved_zero_a: assert property (RD_DATA[15:13] == 3'h0 && !RD_DATA[0])
    else $error("reserved read bit set");
  rail_low_out_a: assert property (RAIL_UVLO |-> GPIO_OUT == 3'h0)
    else $error("outputs not low on rail loss");
  load_pulse_a: assert property ($rose(CFG_LOAD) |=> !CFG_LOAD)
    else $error("load pulse too long");
endmodule : sfsl_fault_log_asserts

// *** dv/sfsl_host.sv ***
// Host model that issues command and read requests on the command port.
`timescale 1ns/1ps
module sfsl_host (
  input  wire logic        CLK,
  input  wire logic        CMD_ACK,
  input  wire logic [15:0] RD_DATA,
  output logic             CMD_VALID,
  output logic [7:0]       CMD_CODE,
  output logic             CMD_READ
);
  initial begin
    {CMD_VALID, CMD_READ, CMD_CODE} = {2'b00, 8'h5a};
  end
  task automatic xfer(input logic [7:0] c, input int tries,
                      output logic [15:0] d, output logic ok);
    ok = 1'b0;
    {CMD_VALID, CMD_READ, CMD_CODE} = {2'b11, c};
    for (int i = 0; i < tries && !ok; i++) begin
      @(posedge CLK);
      ok = CMD_ACK;
    end
    #1;
    // Released code lines do not keep their last value.
    {CMD_VALID, CMD_READ, CMD_CODE} = {2'b00, ~c};
    @(posedge CLK);
    #1;
    d = RD_DATA;
  endtask : xfer
endmodule : sfsl_host

// *** dv/tb_top.sv ***
// Self-checking bench for the fault status and log block.
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  err_total++; $display("unexpected %0t: %h %h", $time, a, b); end end
module tb_top;
  logic        CLK, SYS_RST, CMD_VALID, CMD_READ, CMD_ACK, BUSY, ok;
  logic        CFG_LOAD, RAIL_UVLO, MANUAL_RESET_CLEARS_LOG, ALERT_SET, ALERT;
  logic [7:0]  CMD_CODE;
  logic [15:0] RD_DATA, WORK_CFG, NV_CFG_OUT, d;
  logic [5:0]  CMP_ABOVE_HI, CMP_ABOVE_LO;
  logic [5:0]  HIGH_COMPARE_POLARITY, LOW_COMPARE_POLARITY;
  logic [2:0]  INPUT1_FUNCTION_SELECT, INPUT2_FUNCTION_SELECT;
  logic [2:0]  GPIO_REQ, GPIO_OUT;
  logic [1:0]  GENERAL_INPUT_PIN_N;
  int          err_total = 0;
  int          total_checks = 0;
  sfsl_fault_log #(.CLEAR_CYC(4), .SAVE_CYC(4), .LOAD_CYC(3)) DUT (.*);
  sfsl_host host (.*);
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic step(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : step
  task automatic idle();
    for (int i = 0; i < 40 && BUSY !== 1'b0; i++) step(1);
    if (BUSY !== 1'b0) begin
      err_total++;
      print_verdict();
    end
  endtask : idle
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    host.xfer(c, 8, d, ok);
    `CHK(ok, 1'b1)
    `CHK(d, e)
  endtask : rd
  task automatic cmd(input logic [7:0] c);
    host.xfer(c, 8, d, ok);
    `CHK(ok, 1'b1)
    idle();
  endtask : cmd
  task automatic t_live();
    rd(8'h11, 16'h0000);
    for (int n = 0; n < 6; n++) begin
      CMP_ABOVE_HI = 6'h01 << n;
      rd(8'h1f, 16'h0004 << (2 * n));
    end
    {CMP_ABOVE_HI, CMP_ABOVE_LO} = 12'h000;
    rd(8'h1f, 16'h0aaa);
    {HIGH_COMPARE_POLARITY, LOW_COMPARE_POLARITY} = {6'h00, 6'h3f};
    rd(8'h1f, 16'h1554);
    {HIGH_COMPARE_POLARITY, LOW_COMPARE_POLARITY} = {6'h3f, 6'h00};
    CMP_ABOVE_LO = 6'h3f;
    rd(8'h11, 16'h1ffe);
    $display("live test done");
  endtask : t_live
  task automatic t_supp();
    {CMP_ABOVE_HI, CMP_ABOVE_LO} = {6'h3f, 6'h00};
    {INPUT1_FUNCTION_SELECT, GENERAL_INPUT_PIN_N} = {3'h2, 2'b10};
    rd(8'h1f, 16'h0000);
    {INPUT1_FUNCTION_SELECT, INPUT2_FUNCTION_SELECT} = {3'h0, 3'h3};
    GENERAL_INPUT_PIN_N = 2'b01;
    rd(8'h1f, 16'h1554);
    GENERAL_INPUT_PIN_N = 2'b11;
    rd(8'h1f, 16'h1ffe);
    {CMP_ABOVE_HI, CMP_ABOVE_LO, INPUT2_FUNCTION_SELECT} =
      {6'h00, 6'h3f, 3'h0};
    $display("suppress test done");
  endtask : t_supp
  task automatic t_nv();
    cmd(8'h1d);
    rd(8'h1e, 16'h0004);
    host.xfer(8'h1b, 8, d, ok);
    `CHK(ok, 1'b1)
    host.xfer(8'h11, 1, d, ok);
    `CHK(ok, 1'b0)
    idle();
    rd(8'h11, 16'h0000);
    cmd(8'h1c);
    `CHK(NV_CFG_OUT, WORK_CFG)
    cmd(8'h1d);
    rd(8'h1e, 16'h0000);
    $display("nonvolatile test done");
  endtask : t_nv
  task automatic t_mr();
    CMP_ABOVE_HI = 6'h02;
    step(2);
    CMP_ABOVE_HI = 6'h00;
    rd(8'h11, 16'h0010);
    MANUAL_RESET_CLEARS_LOG = 1'b1;
    {INPUT1_FUNCTION_SELECT, GENERAL_INPUT_PIN_N} = {3'h1, 2'b10};
    step(3);
    GENERAL_INPUT_PIN_N = 2'b11;
    rd(8'h11, 16'h0000);
    {RAIL_UVLO, ALERT_SET} = 2'b11;
    step(1);
    `CHK(GPIO_OUT, 3'h0)
    `CHK(ALERT, 1'b1)
    {RAIL_UVLO, ALERT_SET} = 2'b00;
    rd(8'h11, 16'h0000);
    `CHK(ALERT, 1'b0)
    $display("reset and alert test done");
  endtask : t_mr
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  initial begin
    {SYS_RST, RAIL_UVLO, ALERT_SET, MANUAL_RESET_CLEARS_LOG} = 4'h8;
    {CMP_ABOVE_HI, CMP_ABOVE_LO} = {6'h00, 6'h3f};
    {HIGH_COMPARE_POLARITY, LOW_COMPARE_POLARITY} = {6'h3f, 6'h00};
    {INPUT1_FUNCTION_SELECT, INPUT2_FUNCTION_SELECT} = 6'h00;
    {GENERAL_INPUT_PIN_N, GPIO_REQ, WORK_CFG} = {2'b11, 3'h7, 16'ha5c3};
    step(10);
    SYS_RST = 1'b0;
    idle();
    t_live();
    t_supp();
    t_nv();
    t_mr();
    print_verdict();
  end
endmodule : tb_top
bind sfsl_fault_log sfsl_fault_log_asserts #(
  .CLEAR_CYC(CLEAR_CYC), .SAVE_CYC(SAVE_CYC), .LOAD_CYC(LOAD_CYC)
) chk (.*);

// *** rtl/sfsl_defs.svh ***
// Register offsets, field positions, reset values and timing counts.
`ifndef SFSL_DEFS_SVH
`define SFSL_DEFS_SVH
`define SFSL_CMD_HISTORY   8'h11
`define SFSL_CMD_CLEAR     8'h1b
`define SFSL_CMD_SAVE      8'h1c
`define SFSL_CMD_RELOAD    8'h1d
`define SFSL_CMD_SNAPSHOT  8'h1e
`define SFSL_CMD_LIVE      8'h1f
`define SFSL_FAULT_LSB     1
`define SFSL_FAULT_MSB     12
`define SFSL_WORD_RESET    16'h0000
`define SFSL_FN_SUPPRESS   3'h2
`define SFSL_FN_UVIGNORE   3'h3
`define SFSL_FN_MANRESET   3'h1
`define SFSL_CLEAR_TIME_US 10000
`define SFSL_LOAD_TIME_US  200
`define SFSL_SAVE_TIME_US  10000
`define SFSL_CLK_MHZ       10
`endif

// *** rtl/sfsl_fault_log.sv ***
// Fault status, sticky history, nonvolatile snapshot and config save/reload.
//
// Summary of operation
// (RULE_01) Any reported channel fault sets its sticky history bit until cleared.
// (RULE_02) History starts empty at power-on.
// (RULE_03) Clear command empties history; live status stays untouched.
// (RULE_04) Manual reset clears history when the option bit is set.
// (RULE_05) No other transaction acknowledged while a clear runs.
// (RULE_06) History bit 12 is channel six high down to bit 1 channel one low.
// (RULE_07) Save copies config to nonvolatile; reload copies it back.
// (RULE_08) Saved contents are restored automatically at power-up.
// (RULE_09) First fault after a clear log writes history into the snapshot.
// (RULE_10) Further snapshot writes inhibited until the next clear command.
// (RULE_11) Host reloads then reads the snapshot word to see it.
// (RULE_12) Clear then save stores an all-clear snapshot.
// (RULE_13) Snapshot uses the same bit placement as history.
// (RULE_14) Live status read returns current comparator outputs unlatched.
// (RULE_15) Inputs set to codes 010b or 011b and asserted suppress faults.
// (RULE_16) High bit faults above threshold when polarity one, else below.
// (RULE_17) Low bit faults below threshold when polarity zero, else above.
// (RULE_18) Power-up loads nonvolatile contents within the load time.
// (RULE_19) Rail undervoltage drives all general outputs low.
// (RULE_20) Commands ignored during any nonvolatile save or load.
// (RULE_21) Undervoltage-ignore input low masks undervoltage faults.
// (RULE_22) Fault-suppress input low masks all faults.
// (RULE_23) History read or clear drops alert unless condition persists.
// (RULE_24) Reserved bits read zero and ignore writes.
// (RULE_25) A fault in the clear cycle stays logged.
`timescale 1ns/1ps
`include "sfsl_defs.svh"
module sfsl_fault_log
  import sfsl_pkg::*;
#(
  parameter int CHANNELS   = 6,
  parameter int CFG_W      = 16,
  parameter int CLEAR_CYC  = `SFSL_CLEAR_TIME_US * `SFSL_CLK_MHZ,
  parameter int SAVE_CYC   = `SFSL_SAVE_TIME_US * `SFSL_CLK_MHZ,
  parameter int LOAD_CYC   = `SFSL_LOAD_TIME_US * `SFSL_CLK_MHZ
) (
  input  wire logic                CLK,
  input  wire logic                SYS_RST,
  input  wire logic                CMD_VALID,
  input  wire logic [7:0]          CMD_CODE,
  input  wire logic                CMD_READ,
  output logic                     CMD_ACK,
  output logic [15:0]              RD_DATA,
  output logic                     BUSY,
  input  wire logic [CHANNELS-1:0] CMP_ABOVE_HI,
  input  wire logic [CHANNELS-1:0] CMP_ABOVE_LO,
  input  wire logic [CHANNELS-1:0] HIGH_COMPARE_POLARITY,
  input  wire logic [CHANNELS-1:0] LOW_COMPARE_POLARITY,
  input  wire logic [2:0]          INPUT1_FUNCTION_SELECT,
  input  wire logic [2:0]          INPUT2_FUNCTION_SELECT,
  input  wire logic [1:0]          GENERAL_INPUT_PIN_N,
  input  wire logic                MANUAL_RESET_CLEARS_LOG,
  input  wire logic [CFG_W-1:0]    WORK_CFG,
  output logic [CFG_W-1:0]         NV_CFG_OUT,
  output logic                     CFG_LOAD,
  input  wire logic                RAIL_UVLO,
  input  wire logic [2:0]          GPIO_REQ,
  output logic [2:0]               GPIO_OUT,
  input  wire logic                ALERT_SET,
  output logic                     ALERT
);

  function automatic logic fn_active(input logic [2:0] sel,
                                     input logic [2:0] code,
                                     input logic       pin_n);
    fn_active = (sel == code) && !pin_n;
  endfunction : fn_active

  logic [CHANNELS-1:0] hi_fault;
  logic [CHANNELS-1:0] lo_fault;
  logic                suppress_all;
  logic                ignore_uv;
  logic                mr_active;
  logic [15:0]         live_word;

  assign suppress_all =
    fn_active(INPUT1_FUNCTION_SELECT, `SFSL_FN_SUPPRESS,
              GENERAL_INPUT_PIN_N[0]) ||
    fn_active(INPUT2_FUNCTION_SELECT, `SFSL_FN_SUPPRESS,
              GENERAL_INPUT_PIN_N[1]);                  // RULE_15 RULE_22
  assign ignore_uv =
    fn_active(INPUT1_FUNCTION_SELECT, `SFSL_FN_UVIGNORE,
              GENERAL_INPUT_PIN_N[0]) ||
    fn_active(INPUT2_FUNCTION_SELECT, `SFSL_FN_UVIGNORE,
              GENERAL_INPUT_PIN_N[1]);                  // RULE_15 RULE_21
  assign mr_active = MANUAL_RESET_CLEARS_LOG &&
    (fn_active(INPUT1_FUNCTION_SELECT, `SFSL_FN_MANRESET,
               GENERAL_INPUT_PIN_N[0]) ||
     fn_active(INPUT2_FUNCTION_SELECT, `SFSL_FN_MANRESET,
               GENERAL_INPUT_PIN_N[1]));                // RULE_04

  // A fault is undervoltage type when it trips on a falling input.
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      logic hi_raw;
      logic lo_raw;
      assign hi_raw = HIGH_COMPARE_POLARITY[g] ? CMP_ABOVE_HI[g]
                                               : !CMP_ABOVE_HI[g]; // RULE_16
      assign lo_raw = LOW_COMPARE_POLARITY[g] ? CMP_ABOVE_LO[g]
                                              : !CMP_ABOVE_LO[g]; // RULE_17
      assign hi_fault[g] = hi_raw && !suppress_all &&
                           !(ignore_uv && !HIGH_COMPARE_POLARITY[g]);
      assign lo_fault[g] = lo_raw && !suppress_all &&
                           !(ignore_uv && !LOW_COMPARE_POLARITY[g]);
      assign live_word[2*g+2] = hi_fault[g];            // RULE_06
      assign live_word[2*g+1] = lo_fault[g];            // RULE_13
    end
  endgenerate
  assign live_word[0]     = 1'b0;                       // RULE_24
  assign live_word[15:13] = 3'h0;                       // RULE_24

  sfsl_state_t      state_q,    state_d;
  logic [31:0]      cnt_q,      cnt_d;
  logic [15:0]      snap_q,     snap_d;
  logic             load_q,     load_d;
  logic [15:0]      rd_q,       rd_d;
  logic             alert_q,    alert_d;
  logic [15:0]      hist_q,     hist_d;
  logic             inhibit_q,  inhibit_d;
  logic [15:0]      nv_snap_q,  nv_snap_d;
  logic [CFG_W-1:0] nv_cfg_q,   nv_cfg_d;
  logic             ack;
  logic             idle;
  logic             clear_done;
  logic             save_done;
  logic             do_clear;
  logic             new_fault;

  assign idle      = (state_q == SFSL_IDLE);
  assign ack       = CMD_VALID && idle;                 // RULE_05 RULE_20
  assign new_fault = |live_word;

  // True on the last cycle of a timed nonvolatile or clear operation.
  function automatic logic count_done(input logic [31:0] cnt,
                                      input int          limit);
    count_done = (cnt >= 32'(limit - 1));
  endfunction : count_done

  // Sequencer: power-up load first, then one command at a time.
  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    snap_d     = snap_q;
    load_d     = 1'b0;
    rd_d       = rd_q;
    alert_d    = alert_q || ALERT_SET;
    clear_done = 1'b0;
    save_done  = 1'b0;
    case (state_q)
      SFSL_POWERUP: begin
        cnt_d = cnt_q + 32'd1;
        if (count_done(cnt_q, LOAD_CYC)) begin          // RULE_18
          snap_d  = nv_snap_q;                          // RULE_08
          load_d  = 1'b1;
          state_d = SFSL_IDLE;
          cnt_d   = 32'd0;
        end
      end
      SFSL_IDLE: begin
        if (ack) begin
          cnt_d = 32'd0;
          case (CMD_CODE)
            `SFSL_CMD_CLEAR:    state_d = SFSL_CLEAR;
            `SFSL_CMD_SAVE:     state_d = SFSL_SAVE;
            `SFSL_CMD_RELOAD:   state_d = SFSL_RELOAD;
            `SFSL_CMD_HISTORY: begin
              rd_d    = hist_q;
              alert_d = new_fault;                      // RULE_23
            end
            `SFSL_CMD_SNAPSHOT: rd_d = snap_q;          // RULE_11
            `SFSL_CMD_LIVE:     rd_d = live_word;       // RULE_14
            default:            rd_d = `SFSL_WORD_RESET;
          endcase
        end
      end
      SFSL_CLEAR: begin
        cnt_d = cnt_q + 32'd1;
        if (count_done(cnt_q, CLEAR_CYC)) begin         // RULE_05
          clear_done = 1'b1;                            // RULE_03
          alert_d    = new_fault;                       // RULE_23
          state_d    = SFSL_IDLE;
        end
      end
      SFSL_SAVE: begin
        cnt_d = cnt_q + 32'd1;
        if (count_done(cnt_q, SAVE_CYC)) begin          // RULE_20
          save_done = 1'b1;                             // RULE_07
          state_d   = SFSL_IDLE;
        end
      end
      SFSL_RELOAD: begin
        cnt_d = cnt_q + 32'd1;
        if (count_done(cnt_q, LOAD_CYC)) begin          // RULE_20
          load_d  = 1'b1;                               // RULE_07
          snap_d  = nv_snap_q;
          state_d = SFSL_IDLE;
        end
      end
      default: state_d = SFSL_POWERUP;
    endcase
  end

  // Fault log: a live fault is ORed in after any clear, so it never drops.
  always_comb begin
    hist_d    = hist_q;
    inhibit_d = inhibit_q;
    nv_snap_d = nv_snap_q;
    nv_cfg_d  = nv_cfg_q;
    do_clear  = clear_done || mr_active;                // RULE_03 RULE_04
    if (clear_done) begin
      inhibit_d = 1'b0;                                 // RULE_10
    end
    if (save_done) begin
      nv_cfg_d  = WORK_CFG;                             // RULE_07
      nv_snap_d = hist_q;                               // RULE_12
    end
    if (do_clear) begin
      hist_d = `SFSL_WORD_RESET;                        // RULE_03
    end
    hist_d = hist_d | live_word;                        // RULE_01 RULE_25
    if (new_fault && !inhibit_d && hist_q == `SFSL_WORD_RESET) begin
      nv_snap_d = hist_d;                               // RULE_09
      inhibit_d = 1'b1;                                 // RULE_10
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_q <= SFSL_POWERUP;
      cnt_q   <= 32'd0;
      snap_q  <= `SFSL_WORD_RESET;
      load_q  <= 1'b0;
      rd_q    <= `SFSL_WORD_RESET;
      alert_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      snap_q  <= snap_d;
      load_q  <= load_d;
      rd_q    <= rd_d;
      alert_q <= alert_d;
    end
  end

  // History and the snapshot inhibit are volatile and start empty.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      hist_q    <= `SFSL_WORD_RESET;                    // RULE_02
      inhibit_q <= 1'b0;
    end else begin
      hist_q    <= hist_d;
      inhibit_q <= inhibit_d;
    end
  end

  // Nonvolatile contents survive the power-on reset.
  always_ff @(posedge CLK) begin
    nv_snap_q <= nv_snap_d;
    nv_cfg_q  <= nv_cfg_d;
  end

  assign CMD_ACK    = ack;
  assign BUSY       = !idle;
  assign RD_DATA    = rd_q;
  assign NV_CFG_OUT = nv_cfg_q;
  assign CFG_LOAD   = load_q;
  assign ALERT      = alert_q;
  assign GPIO_OUT   = RAIL_UVLO ? 3'h0 : GPIO_REQ;      // RULE_19

endmodule : sfsl_fault_log

// *** rtl/sfsl_pkg.sv ***
// Types shared by the fault status and log block.
package sfsl_pkg;
  typedef enum logic [4:0] {
    SFSL_POWERUP = 5'b00001,
    SFSL_IDLE    = 5'b00010,
    SFSL_CLEAR   = 5'b00100,
    SFSL_SAVE    = 5'b01000,
    SFSL_RELOAD  = 5'b10000
  } sfsl_state_t;
endpackage : sfsl_pkg
